/* File: src/pcg_port.sv */
// Port C general-purpose I/O with peripheral pin multiplexing
`include "pcg_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pcg_port (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // Register port
   input  wire logic [`PCG_ADDR_W-1:0]        reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output var  logic [7:0]                    reg_rdata,
   // Pins
   input  wire logic [7:0]                    pad_in,
   output var  logic [7:0]                    pad_out,
   output var  logic [7:0]                    pad_oe,
   output var  logic                          pad_analog_0,
   output var  logic                          pad_analog_1,
   // Configuration bit for second capture pin placement
   input  wire logic                          second_capture_pin_select,
   // Peripheral side
   input  wire pcg_pkg::pcg_ccp_out_t         first_capture_compare_unit,
   input  wire pcg_pkg::pcg_ccp_out_t         second_capture_compare_unit,
   output var  logic                          timer_external_count_input,
   output var  logic                          first_capture_in,
   output var  logic                          second_capture_in,
   output var  logic                          second_capture_alt_en,
   output var  pcg_pkg::pcg_ccp_out_t         second_capture_alt_out
);

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   logic [7:0] port_c_output_latch;
   logic [7:0] port_c_direction;
   logic [7:0] periph_ctrl;
   logic [7:0] next_latch;
   logic [7:0] next_direction;
   logic [7:0] next_ctrl;
   logic [7:0] next_rdata;
   logic [7:0] port_c_pin_level;

   logic tosc_en;
   logic ccp1_en;
   logic ccp2_en;
   logic pwm1_en;
   logic pwm2_en;
   logic pwm1_tri;
   logic pwm2_tri;
   logic ccp2_here;

   assign tosc_en   = periph_ctrl[`PCG_CTRL_TOSC_EN];
   assign ccp1_en   = periph_ctrl[`PCG_CTRL_CCP1_EN];
   assign ccp2_en   = periph_ctrl[`PCG_CTRL_CCP2_EN];
   assign pwm1_en   = periph_ctrl[`PCG_CTRL_PWM1_EN];
   assign pwm2_en   = periph_ctrl[`PCG_CTRL_PWM2_EN];
   assign pwm1_tri  = periph_ctrl[`PCG_CTRL_PWM1_TRI];
   assign pwm2_tri  = periph_ctrl[`PCG_CTRL_PWM2_TRI];
   assign ccp2_here = second_capture_pin_select;

   // --------------------------------------------------------------
   // Pin synchroniser
   // --------------------------------------------------------------
   pcg_sync u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (pad_in),
      .stable   (port_c_pin_level)
   );

   // --------------------------------------------------------------
   // Register access
   // --------------------------------------------------------------
   always_comb begin
      next_latch     = port_c_output_latch;
      next_direction = port_c_direction;
      next_ctrl      = periph_ctrl;
      if (reg_wr) begin
         unique case (reg_addr)
            `PCG_OFF_PIN_LEVEL:   next_latch     = reg_wdata;
            `PCG_OFF_LATCH:       next_latch     = reg_wdata;
            `PCG_OFF_DIRECTION:   next_direction = reg_wdata;
            `PCG_OFF_PERIPH_CTRL: next_ctrl      = {1'b0, reg_wdata[6:0]};
            default: ;
         endcase
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `PCG_OFF_PIN_LEVEL:   next_rdata = port_c_pin_level;
            `PCG_OFF_LATCH:       next_rdata = port_c_output_latch;
            `PCG_OFF_DIRECTION:   next_rdata = port_c_direction;
            `PCG_OFF_PERIPH_CTRL: next_rdata = periph_ctrl;
            `PCG_OFF_PERIPH_STAT: next_rdata = {4'h0, second_capture_pin_select, tosc_en, pad_oe[1], pad_oe[0]};
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_c_output_latch <= `PCG_LATCH_RESET;
         port_c_direction    <= `PCG_DIR_RESET;
         periph_ctrl         <= `PCG_CTRL_RESET;
         reg_rdata           <= 8'h00;
      end else begin
         port_c_output_latch <= next_latch;
         port_c_direction    <= next_direction;
         periph_ctrl         <= next_ctrl;
         reg_rdata           <= next_rdata;
      end
   end

   // --------------------------------------------------------------
   // Pin multiplexing
   // --------------------------------------------------------------
   function automatic logic pwm_drive(input logic en, input logic tri_cfg, input pcg_pkg::pcg_ccp_out_t u);
      pwm_drive = en && !(tri_cfg && u.shutdown);
   endfunction : pwm_drive

   pcg_pkg::pcg_pad_drive_t next_pad;
   logic                    next_analog_0;
   logic                    next_analog_1;
   logic                    next_count;
   logic                    next_cap1;
   logic                    next_cap2;
   logic                    next_alt_en;
   pcg_pkg::pcg_ccp_out_t   next_alt_out;

   always_comb begin
      // Plain GPIO by default
      next_pad.o  = port_c_output_latch;
      next_pad.oe = ~port_c_direction;

      // First capture unit on bit 2
      if (pwm1_en) begin
         next_pad.o[`PCG_PIN_CCP1]  = first_capture_compare_unit.pwm_a;
         next_pad.oe[`PCG_PIN_CCP1] = pwm_drive(1'b1, pwm1_tri, first_capture_compare_unit);
      end else if (ccp1_en && !port_c_direction[`PCG_PIN_CCP1]) begin
         next_pad.o[`PCG_PIN_CCP1]  = first_capture_compare_unit.cmp;
      end

      // Second capture unit on bit 1 when selected here
      if (ccp2_here && pwm2_en) begin
         next_pad.o[`PCG_PIN_CCP2]  = second_capture_compare_unit.pwm_a;
         next_pad.oe[`PCG_PIN_CCP2] = pwm_drive(1'b1, pwm2_tri, second_capture_compare_unit);
      end else if (ccp2_here && ccp2_en && !port_c_direction[`PCG_PIN_CCP2]) begin
         next_pad.o[`PCG_PIN_CCP2]  = second_capture_compare_unit.cmp;
      end

      // Timer oscillator owns bits 0 and 1
      if (tosc_en) begin
         next_pad.o[`PCG_PIN_TOSC_OUT]  = 1'b0;
         next_pad.oe[`PCG_PIN_TOSC_OUT] = 1'b0;
         next_pad.o[`PCG_PIN_TOSC_IN]   = 1'b0;
         next_pad.oe[`PCG_PIN_TOSC_IN]  = 1'b0;
      end
      next_analog_0 = tosc_en;
      next_analog_1 = tosc_en;

      next_count = !tosc_en && port_c_direction[`PCG_PIN_TOSC_OUT]
                   && port_c_pin_level[`PCG_PIN_TOSC_OUT];
      next_cap1  = port_c_direction[`PCG_PIN_CCP1] && port_c_pin_level[`PCG_PIN_CCP1];
      next_cap2  = ccp2_here && !tosc_en && port_c_direction[`PCG_PIN_CCP2]
                   && port_c_pin_level[`PCG_PIN_CCP2];

      // Hand the second unit to its alternate pin when not selected here
      next_alt_en  = !ccp2_here && (ccp2_en || pwm2_en);
      next_alt_out = ccp2_here ? '0 : second_capture_compare_unit;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_out                    <= 8'h00;
         pad_oe                     <= 8'h00;
         pad_analog_0               <= 1'b0;
         pad_analog_1               <= 1'b0;
         timer_external_count_input <= 1'b0;
         first_capture_in           <= 1'b0;
         second_capture_in          <= 1'b0;
         second_capture_alt_en      <= 1'b0;
         second_capture_alt_out     <= '0;
      end else begin
         pad_out                    <= next_pad.o;
         pad_oe                     <= next_pad.oe;
         pad_analog_0               <= next_analog_0;
         pad_analog_1               <= next_analog_1;
         timer_external_count_input <= next_count;
         first_capture_in           <= next_cap1;
         second_capture_in          <= next_cap2;
         second_capture_alt_en      <= next_alt_en;
         second_capture_alt_out     <= next_alt_out;
      end
   end

endmodule : pcg_port

`default_nettype wire

/* File: src/pcg_defs.svh */
// Register offsets, field positions and reset values of the port C block
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

`define PCG_ADDR_W          4
`define PCG_OFF_PIN_LEVEL   4'h0
`define PCG_OFF_LATCH       4'h1
`define PCG_OFF_DIRECTION   4'h2
`define PCG_OFF_PERIPH_CTRL 4'h3
`define PCG_OFF_PERIPH_STAT 4'h4

`define PCG_DIR_RESET       8'hff
`define PCG_LATCH_RESET     8'h00
`define PCG_CTRL_RESET      8'h00

// Peripheral control register fields
`define PCG_CTRL_TOSC_EN    0
`define PCG_CTRL_CCP2_EN    1
`define PCG_CTRL_CCP1_EN    2
`define PCG_CTRL_PWM2_EN    3
`define PCG_CTRL_PWM1_EN    4
`define PCG_CTRL_PWM2_TRI   5
`define PCG_CTRL_PWM1_TRI   6

`define PCG_PIN_TOSC_OUT    0
`define PCG_PIN_TOSC_IN     1
`define PCG_PIN_CCP2        1
`define PCG_PIN_CCP1        2

`endif

/* File: src/pcg_pkg.sv */
// Types shared by the port C block
package pcg_pkg;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } pcg_pad_drive_t;

   typedef struct packed {
      logic cmp;
      logic pwm_a;
      logic shutdown;
   } pcg_ccp_out_t;

   typedef struct packed {
      logic capture;
      logic count;
   } pcg_periph_in_t;

endpackage : pcg_pkg

/* File: src/pcg_sync.sv */
// Three-stage pin synchroniser for the port C inputs
`timescale 1ns/1ns
`default_nettype none

module pcg_sync (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] async_in,
   output var  logic [7:0] stable
);

   logic [7:0] s1;
   logic [7:0] s2;
   logic [7:0] s3;
   logic [7:0] next_stable;

   // --------------------------------------------------------------
   // Change accepted once second and third stage agree
   // --------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable[i];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1     <= 8'h00;
         s2     <= 8'h00;
         s3     <= 8'h00;
         stable <= 8'h00;
      end else begin
         s1     <= async_in;
         s2     <= s1;
         s3     <= s2;
         stable <= next_stable;
      end
   end

endmodule : pcg_sync

`default_nettype wire

/* File: bench/pcg_board.sv */
// Board-side model of the port C pins
`timescale 1ns/1ns
`default_nettype none
module pcg_board (
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] ext_level,
   output var  logic [7:0] pad_in
);
   // Driven pins read back the port level, others the board level
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pcg_board
`default_nettype wire

/* File: bench/pcg_port_chk.sv */
// Concurrent checks on the port C block ports
`timescale 1ns/1ns
`default_nettype none
`include "pcg_defs.svh"
module pcg_port_chk (
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire logic [`PCG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [7:0]             reg_rdata,
   input wire logic [7:0]             pad_in,
   input wire logic [7:0]             pad_out,
   input wire logic [7:0]             pad_oe,
   input wire logic                   pad_analog_0,
   input wire logic                   pad_analog_1,
   input wire logic                   second_capture_pin_select,
   input wire logic                   timer_external_count_input,
   input wire logic                   second_capture_alt_en
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ----
   // Properties
   // ----
   chk_reset_idle: assert property ($fell(sys_rst) |-> pad_oe == 8'h00 && reg_rdata == 8'h00)
      else $error("pads or read data not idle after reset");
   chk_dir_readback: assert property (reg_wr && reg_addr == 4'h2 ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h2
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("direction read differs from write");
   chk_latch_readback: assert property (reg_wr && reg_addr == 4'h1 ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h1
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("latch read differs from write");
   chk_dir_drives_oe: assert property (reg_wr && reg_addr == 4'h2
      |-> ##2 pad_oe[7:3] == ~$past(reg_wdata[7:3], 2)) else $error("enable does not follow direction");
   chk_latch_drives_pin: assert property (reg_wr && reg_addr == 4'h1
      |-> ##2 (pad_out[7:3] & pad_oe[7:3]) == ($past(reg_wdata[7:3], 2) & pad_oe[7:3]))
      else $error("driven pin differs from latch");
   chk_osc_pins_off: assert property (pad_analog_0 |-> pad_analog_1 && pad_oe[1:0] == 2'b00)
      else $error("oscillator pins still digital");
   chk_alt_pin_sel: assert property (second_capture_alt_en |-> !$past(second_capture_pin_select))
      else $error("alternate pin used with select set");
   chk_count_input: assert property (($stable(pad_in[0]) && !pad_oe[0] && !pad_analog_0) [*6]
      |-> timer_external_count_input == pad_in[0]) else $error("count input not pin 0");
   chk_pin_level_read: assert property ($stable(pad_in) [*6] ##0 (reg_rd && reg_addr == 4'h0)
      |=> reg_rdata == $past(pad_in)) else $error("pin level read wrong");
endmodule : pcg_port_chk
bind pcg_port pcg_port_chk chk_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .pad_in, .pad_out, .pad_oe, .pad_analog_0, .pad_analog_1, .second_capture_pin_select,
   .timer_external_count_input, .second_capture_alt_en);
`default_nettype wire

/* File: bench/port_c_general_io_bench.sv */
// Self-checking bench for the port C block
`timescale 1ns/1ns
`default_nettype none
`include "pcg_defs.svh"
module port_c_general_io_bench;
   logic                   clk, sys_rst, reg_wr, reg_rd, sel, an0, an1, cnt, cap1, cap2, alt_en;
   logic [`PCG_ADDR_W-1:0] reg_addr;
   logic [7:0]             reg_wdata, reg_rdata, pad_in, pad_out, pad_oe, ext_level, rd_v, d, l, e;
   pcg_pkg::pcg_ccp_out_t  ccp1, ccp2, alt_out;
   int                     error_cnt, samples_checked;
   pcg_port dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_in,
      .pad_out, .pad_oe, .pad_analog_0(an0), .pad_analog_1(an1), .second_capture_pin_select(sel),
      .first_capture_compare_unit(ccp1), .second_capture_compare_unit(ccp2),
      .timer_external_count_input(cnt), .first_capture_in(cap1), .second_capture_in(cap2),
      .second_capture_alt_en(alt_en), .second_capture_alt_out(alt_out));
   pcg_board board_u (.pad_out, .pad_oe, .ext_level, .pad_in);
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   // Level expected on each pin from direction, latch and board
   function automatic logic [7:0] pins(input logic [7:0] dd, input logic [7:0] ll, input logic [7:0] ee);
      return (~dd & ll) | (dd & ee);
   endfunction : pins
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, sel} = {3'b100, 12'h000, 1'b1};
      {ccp1, ccp2, ext_level, error_cnt, samples_checked} = {6'h00, 8'h5a, 64'h0};
      void'($urandom(32'hbbc7));
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h2);
      chk(rd_v, `PCG_DIR_RESET);
      chk(pad_oe, 8'h00);
      rd(4'h9);
      chk(rd_v, 8'h00);
      repeat (16) begin
         {d, l, e} = 24'($urandom);
         @(posedge clk);
         ext_level <= e;
         wr(4'h2, d);
         rd(4'h2);
         chk(rd_v, d);
         wr(4'h1, l);
         rd(4'h1);
         chk(rd_v, l);
         settle(6);
         chk(pad_oe, ~d);
         chk(pad_out & ~d, l & ~d);
         rd(4'h0);
         chk(rd_v, pins(d, l, e));
      end
      wr(4'h0, 8'h3c);
      rd(4'h1);
      chk(rd_v, 8'h3c);
      $display("test register and pin traffic done");
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h01);
      settle(3);
      chk({4'h0, an1, an0, pad_oe[1:0]}, 8'h0c);
      rd(4'h4);
      chk(rd_v, 8'h0c);
      wr(4'h2, 8'hff);
      ccp2 <= 3'b010;
      wr(4'h3, 8'h28);
      settle(3);
      chk({pad_oe[1], pad_out[1]}, 8'h03);
      @(posedge clk);
      ccp2 <= 3'b011;
      settle(3);
      chk(pad_oe[1], 8'h00);
      rd(4'h2);
      chk(rd_v, 8'hff);
      @(posedge clk);
      ccp2 <= 3'b010;
      sel <= 1'b0;
      settle(3);
      chk({alt_en, pad_oe[1], alt_out}, 8'h12);
      @(posedge clk);
      sel <= 1'b1;
      $display("test oscillator and pwm done");
      wr(4'h3, 8'h04);
      wr(4'h2, 8'hfb);
      ccp1 <= 3'b100;
      settle(3);
      chk({pad_oe[2], pad_out[2]}, 8'h03);
      e = 8'($urandom);
      @(posedge clk);
      ext_level <= e;
      wr(4'h2, 8'hff);
      settle(7);
      chk({cap1, cnt}, {6'h0, e[2], e[0]});
      chk({7'h0, cap2}, {7'h0, e[1]});
      $display("test capture and count done");
      wr(4'h2, 8'h00);
      settle(2);
      chk(pad_oe, 8'hff);
      @(posedge clk);
      sys_rst <= 1'b1;
      settle(2);
      chk(pad_oe, 8'h00);
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h2);
      chk(rd_v, `PCG_DIR_RESET);
      rd(4'h1);
      chk(rd_v, `PCG_LATCH_RESET);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule : port_c_general_io_bench
`default_nettype wire
